/* fie_pkg.sv */
// Constants shared by the fast interrupt nesting and external trigger block.
// Assumes a 32-bit classic Wishbone register bus and a single 40 MHz clock.
// What this block does
// - With fast nesting on, a read of the fast vector sets the in-service bit at the active level.
// - With fast nesting on, any set in-service bit blocks fast sources at its priority level and every higher-numbered one.
// - Each write to the in-service register clears only its lowest-numbered set bit.
// - Four external pins can each be made level or edge sensitive.
// - Pin n takes its trigger mode from bits 2n+1:2n, 11 fall, 10 rise, 01 low, 00 high.
// - An edge caught on a pin stays pending until a one is written to its clear bit.
// - With nesting off, fast sources work unprioritised and a fast request masks the normal one.
// - Every source owns a three-bit priority field for levels zero to seven.
// - The fast vector shows the winning fast source number, 0 to 19, in bits 6:2.
package fie_pkg;

    localparam int FIE_NSRC = 20;
    localparam int FIE_NEXT = 4;

    // Register byte addresses
    localparam logic [31:0] FIE_A_NEN = 32'hFFFF0008;
    localparam logic [31:0] FIE_A_NCON = 32'hFFFF0030;
    localparam logic [31:0] FIE_A_TCFG = 32'hFFFF0034;
    localparam logic [31:0] FIE_A_ECLR = 32'hFFFF0038;
    localparam logic [31:0] FIE_A_FSTA = 32'hFFFF0100;
    localparam logic [31:0] FIE_A_FEN = 32'hFFFF0110;
    localparam logic [31:0] FIE_A_VEC = 32'hFFFF011C;
    localparam logic [31:0] FIE_A_PRI0 = 32'hFFFF0120;
    localparam logic [31:0] FIE_A_PRI1 = 32'hFFFF0124;
    localparam logic [31:0] FIE_A_PRI2 = 32'hFFFF0128;
    localparam logic [31:0] FIE_A_INS = 32'hFFFF013C;
    localparam logic [31:0] FIE_A_EVST = 32'hFFFF0140;
    localparam logic [31:0] FIE_A_EVMSK = 32'hFFFF0144;

    // Reset values
    localparam logic [19:0] FIE_RST_EN = 20'h00000;
    localparam logic [1:0] FIE_RST_NCON = 2'h0;
    localparam logic [7:0] FIE_RST_TCFG = 8'h00;
    localparam logic [7:0] FIE_RST_INS = 8'h00;
    localparam logic [3:0] FIE_RST_EV = 4'h0;
    localparam logic [59:0] FIE_RST_PRI = 60'h0;

    // Field positions
    localparam int FIE_NCON_FAST_BIT = 1;
    localparam int FIE_VEC_LSB = 2;
    localparam int FIE_PRI_STRIDE = 4;
    localparam int FIE_PRI_PER_REG = 8;
    localparam int FIE_CLR_BIT0 = 13;
    localparam int FIE_CLR_BIT1 = 14;
    localparam int FIE_CLR_BIT2 = 18;
    localparam int FIE_CLR_BIT3 = 19;
    // Source numbers of the external pins
    localparam int FIE_SRC_EXT0 = 11;
    localparam int FIE_SRC_EXT1 = 12;
    localparam int FIE_SRC_EXT2 = 16;
    localparam int FIE_SRC_EXT3 = 17;

    // Trigger mode codes
    localparam logic [1:0] FIE_TRG_HIGH = 2'h0;
    localparam logic [1:0] FIE_TRG_LOW = 2'h1;
    localparam logic [1:0] FIE_TRG_RISE = 2'h2;
    localparam logic [1:0] FIE_TRG_FALL = 2'h3;

    localparam logic [3:0] FIE_NO_LEVEL = 4'h8;

    // Index of lowest set bit, FIE_NO_LEVEL when none
    function automatic logic [3:0] fie_low_set(input logic [7:0] v);
        logic [3:0] r;
        r = FIE_NO_LEVEL;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

endpackage

/* fie_ext_trig.sv */
// External pin trigger logic for four pins: level qualify and edge latch.
// Assumes pins already synchronous to clk_i and one-cycle clear pulses.
`timescale 1ns/1ps
module fie_ext_trig
    import fie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and configuration
    input wire logic [3:0] pin_i,
    input wire logic [7:0] cfg_i,
    input wire logic [3:0] clr_i,
    // Results
    output logic [3:0] req_o,
    output logic [3:0] latch_o,
    output logic [3:0] evt_o
);

    typedef struct packed {
        logic armed;
        logic [3:0] prev;
        logic [3:0] latch;
        logic [3:0] req;
        logic [3:0] evt;
    } fie_ext_s;

    fie_ext_s s_q;
    fie_ext_s s_d;

    always_comb
    begin
        logic [1:0] mode;
        logic hit;
        mode = 2'h0;
        hit = 1'b0;
        s_d = s_q;
        s_d.armed = 1'b1;
        s_d.prev = pin_i;
        for (int n = 0; n < FIE_NEXT; n++)
        begin
            mode = cfg_i[2*n +: 2];
            case (mode)
                FIE_TRG_RISE: hit = s_q.armed && pin_i[n] && !s_q.prev[n];
                FIE_TRG_FALL: hit = s_q.armed && !pin_i[n] && s_q.prev[n];
                default: hit = 1'b0;
            endcase
            s_d.evt[n] = hit;
            // Set wins over a clear in the same cycle
            if (hit)
            begin
                s_d.latch[n] = 1'b1;
            end
            else if (clr_i[n])
            begin
                s_d.latch[n] = 1'b0;
            end
            case (mode)
                FIE_TRG_HIGH: s_d.req[n] = pin_i[n];
                FIE_TRG_LOW: s_d.req[n] = !pin_i[n];
                default: s_d.req[n] = s_d.latch[n];
            endcase
        end
    end

    // First sample only arms, so a pin already high at reset is no edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req_o = s_q.req;
    assign latch_o = s_q.latch;
    assign evt_o = s_q.evt;

endmodule // fie_ext_trig

/* fie_prio_pick.sv */
// Picks the winning fast source among enabled requests.
// Assumes priority fields packed three bits per source.
`timescale 1ns/1ps
module fie_prio_pick
    import fie_pkg::*;
(
    // Requests and settings
    input wire logic [19:0] req_i,
    input wire logic [59:0] prio_i,
    input wire logic nest_i,
    input wire logic [7:0] ins_i,
    // Winner
    output logic any_o,
    output logic [4:0] src_o,
    output logic [2:0] lvl_o
);

    always_comb
    begin
        logic [3:0] lim;
        logic [2:0] p;
        logic ok;
        lim = fie_low_set(ins_i);
        p = 3'h0;
        ok = 1'b0;
        any_o = 1'b0;
        src_o = 5'h00;
        lvl_o = 3'h0;
        for (int i = 0; i < FIE_NSRC; i++)
        begin
            p = prio_i[3*i +: 3];
            ok = req_i[i] && (!nest_i || ({1'b0, p} < lim));
            // Without nesting the lowest source number simply wins
            if (ok && (!any_o || (nest_i && p < lvl_o)))
            begin
                any_o = 1'b1;
                src_o = 5'(i);
                lvl_o = p;
            end
        end
    end

endmodule // fie_prio_pick

/* fie_top.sv */
// Fast interrupt nesting stack, external trigger setup and event status.
// Assumes a classic Wishbone master and peripheral requests synchronous to clk_i.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fie_top
    import fie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sources
    input wire logic [19:0] src_i,
    input wire logic [3:0] ext_pin_i,
    // Processor requests
    output logic fiq_o,
    output logic irq_o,
    // Event interrupt
    output logic evt_irq_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [19:0] fen;
        logic [19:0] nen;
        logic [1:0] ncon;
        logic [59:0] prio;
        logic [7:0] ins;
        logic [7:0] tcfg;
        logic [3:0] ev_st;
        logic [3:0] ev_mask;
        logic vec_hit;
        logic [2:0] vec_lvl;
        logic fiq;
        logic irq;
    } fie_top_s;

    fie_top_s s_q;
    fie_top_s s_d;

    logic [3:0] ext_req;
    logic [3:0] ext_latch;
    logic [3:0] ext_evt;
    logic [3:0] ext_clr;
    logic [19:0] all_req;
    logic pick_any;
    logic [4:0] pick_src;
    logic [2:0] pick_lvl;
    logic nest_on;
    logic req_now;
    logic wr_go;
    logic rd_go;

    // Byte-lane merge for a written word
    function automatic logic [31:0] fie_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Packs one priority bank into nibbles
    function automatic logic [31:0] fie_pri_rd(input logic [59:0] pr, input int bank);
        logic [31:0] r;
        int k;
        r = 32'h0;
        k = 0;
        for (int j = 0; j < FIE_PRI_PER_REG; j++)
        begin
            k = bank * FIE_PRI_PER_REG + j;
            if (k < FIE_NSRC)
            begin
                r[FIE_PRI_STRIDE*j +: 3] = pr[3*k +: 3];
            end
        end
        return r;
    endfunction

    // Unpacks one priority bank from nibbles
    function automatic logic [59:0] fie_pri_wr(input logic [59:0] pr, input int bank,
                                               input logic [31:0] v);
        logic [59:0] r;
        int k;
        r = pr;
        k = 0;
        for (int j = 0; j < FIE_PRI_PER_REG; j++)
        begin
            k = bank * FIE_PRI_PER_REG + j;
            if (k < FIE_NSRC)
            begin
                r[3*k +: 3] = v[FIE_PRI_STRIDE*j +: 3];
            end
        end
        return r;
    endfunction

    assign nest_on = s_q.ncon[FIE_NCON_FAST_BIT];
    assign req_now = wb_cyc_i && wb_stb_i && !s_q.ack;
    // Writes and read side effects land at the edge where ack is sampled
    assign wr_go = wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i;
    assign rd_go = wb_cyc_i && wb_stb_i && s_q.ack && !wb_we_i;

    // Edge clear pulses from a write of ones
    always_comb
    begin
        ext_clr = 4'h0;
        if (wr_go && wb_adr_i == FIE_A_ECLR)
        begin
            ext_clr[0] = wb_dat_i[FIE_CLR_BIT0] && wb_sel_i[1];
            ext_clr[1] = wb_dat_i[FIE_CLR_BIT1] && wb_sel_i[1];
            ext_clr[2] = wb_dat_i[FIE_CLR_BIT2] && wb_sel_i[2];
            ext_clr[3] = wb_dat_i[FIE_CLR_BIT3] && wb_sel_i[2];
        end
    end

    // External pins replace their peripheral request slots
    always_comb
    begin
        all_req = src_i;
        all_req[FIE_SRC_EXT0] = ext_req[0];
        all_req[FIE_SRC_EXT1] = ext_req[1];
        all_req[FIE_SRC_EXT2] = ext_req[2];
        all_req[FIE_SRC_EXT3] = ext_req[3];
    end

    fie_ext_trig u_ext
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_pin_i),
        .cfg_i(s_q.tcfg),
        .clr_i(ext_clr),
        .req_o(ext_req),
        .latch_o(ext_latch),
        .evt_o(ext_evt)
    );

    fie_prio_pick u_pick
    (
        .req_i(all_req & s_q.fen),
        .prio_i(s_q.prio),
        .nest_i(nest_on),
        .ins_i(s_q.ins),
        .any_o(pick_any),
        .src_o(pick_src),
        .lvl_o(pick_lvl)
    );

    always_comb
    begin
        logic [31:0] w;
        logic [31:0] r;
        w = 32'h0;
        r = 32'h0;
        s_d = s_q;
        s_d.ack = req_now;
        s_d.fiq = pick_any;
        // A fast request holds the normal one off
        s_d.irq = (|(all_req & s_q.nen)) && !pick_any;
        // Read data and vector snapshot at request time
        if (req_now)
        begin
            case (wb_adr_i)
                FIE_A_NEN: r = {12'h000, s_q.nen};
                FIE_A_FEN: r = {12'h000, s_q.fen};
                FIE_A_FSTA: r = {12'h000, all_req & s_q.fen};
                FIE_A_NCON: r = {30'h0, s_q.ncon};
                FIE_A_TCFG: r = {24'h000000, s_q.tcfg};
                FIE_A_ECLR:
                begin
                    r[FIE_CLR_BIT0] = ext_latch[0];
                    r[FIE_CLR_BIT1] = ext_latch[1];
                    r[FIE_CLR_BIT2] = ext_latch[2];
                    r[FIE_CLR_BIT3] = ext_latch[3];
                end
                FIE_A_VEC: r[FIE_VEC_LSB +: 5] = pick_src;
                FIE_A_PRI0: r = fie_pri_rd(s_q.prio, 0);
                FIE_A_PRI1: r = fie_pri_rd(s_q.prio, 1);
                FIE_A_PRI2: r = fie_pri_rd(s_q.prio, 2);
                FIE_A_INS: r = {24'h000000, s_q.ins};
                FIE_A_EVST: r = {28'h0, s_q.ev_st};
                FIE_A_EVMSK: r = {28'h0, s_q.ev_mask};
                default: r = 32'h0;
            endcase
            s_d.dat = r;
            s_d.vec_hit = pick_any && nest_on && !wb_we_i && wb_adr_i == FIE_A_VEC;
            s_d.vec_lvl = pick_lvl;
        end
        // Vector read pushes the active level onto the stack
        if (rd_go && s_q.vec_hit)
        begin
            s_d.ins[s_q.vec_lvl] = 1'b1;
        end
        if (wr_go)
        begin
            case (wb_adr_i)
                FIE_A_NEN:
                begin
                    w = fie_merge({12'h000, s_q.nen}, wb_dat_i, wb_sel_i);
                    s_d.nen = w[19:0];
                end
                FIE_A_FEN:
                begin
                    w = fie_merge({12'h000, s_q.fen}, wb_dat_i, wb_sel_i);
                    s_d.fen = w[19:0];
                end
                FIE_A_NCON:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.ncon = wb_dat_i[1:0];
                    end
                end
                FIE_A_TCFG:
                begin
                    // Upper bits are not stored
                    if (wb_sel_i[0])
                    begin
                        s_d.tcfg = wb_dat_i[7:0];
                    end
                end
                FIE_A_PRI0:
                begin
                    w = fie_merge(fie_pri_rd(s_q.prio, 0), wb_dat_i, wb_sel_i);
                    s_d.prio = fie_pri_wr(s_q.prio, 0, w);
                end
                FIE_A_PRI1:
                begin
                    w = fie_merge(fie_pri_rd(s_q.prio, 1), wb_dat_i, wb_sel_i);
                    s_d.prio = fie_pri_wr(s_q.prio, 1, w);
                end
                FIE_A_PRI2:
                begin
                    w = fie_merge(fie_pri_rd(s_q.prio, 2), wb_dat_i, wb_sel_i);
                    s_d.prio = fie_pri_wr(s_q.prio, 2, w);
                end
                FIE_A_INS:
                begin
                    // Any write pops one level; data is ignored
                    s_d.ins = s_q.ins & (s_q.ins - 8'h01);
                end
                FIE_A_EVMSK:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.ev_mask = wb_dat_i[3:0];
                    end
                end
                FIE_A_EVST:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.ev_st = s_q.ev_st & ~wb_dat_i[3:0];
                    end
                end
                default:
                begin
                    s_d.ncon = s_d.ncon;
                end
            endcase
        end
        // New edge events win over a clear
        s_d.ev_st = s_d.ev_st | ext_evt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.ack <= 1'b0;
            s_q.dat <= 32'h0;
            s_q.fen <= FIE_RST_EN;
            s_q.nen <= FIE_RST_EN;
            s_q.ncon <= FIE_RST_NCON;
            s_q.prio <= FIE_RST_PRI;
            s_q.ins <= FIE_RST_INS;
            s_q.tcfg <= FIE_RST_TCFG;
            s_q.ev_st <= FIE_RST_EV;
            s_q.ev_mask <= FIE_RST_EV;
            s_q.vec_hit <= 1'b0;
            s_q.vec_lvl <= 3'h0;
            s_q.fiq <= 1'b0;
            s_q.irq <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
    assign fiq_o = s_q.fiq;
    assign irq_o = s_q.irq;
    assign evt_irq_o = |(s_q.ev_st & s_q.ev_mask);

endmodule // fie_top

/* fie_src_model.sv */
// Far-side model: external pins and peripheral request lines.
// Assumes bench commands change just after a rising edge of clk_i.
`timescale 1ns/1ps
module fie_src_model
    import fie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic [3:0] pin_cmd_i,
    input wire logic [19:0] src_cmd_i,
    // Toward the block
    output logic [3:0] ext_pin_o,
    output logic [19:0] src_o
);
    // Retimed so the block sees pins already synchronous
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_pin_o <= 4'h0;
            src_o <= 20'h00000;
        end
        else
        begin
            ext_pin_o <= pin_cmd_i;
            src_o <= src_cmd_i;
        end
    end
endmodule // fie_src_model

/* fie_top_sva.sv */
// Checker for the fast nesting and trigger block, top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fie_top_sva
    import fie_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [19:0] src_i,
    input wire logic [3:0] ext_pin_i,
    input wire logic fiq_o,
    input wire logic irq_o,
    input wire logic evt_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    logic rd_ack;
    assign rd_ack = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;

    ack_timing_a: assert property (s_req |=> s_ans)
        else $error("ack not a single pulse one cycle after request");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    fast_over_normal_a: assert property (fiq_o |-> !irq_o)
        else $error("normal request alongside fast request");
    vector_range_a: assert property (rd_ack && wb_adr_i == FIE_A_VEC |->
        wb_dat_o[6:2] <= 5'h13 && wb_dat_o[31:7] == 25'h0 && wb_dat_o[1:0] == 2'h0)
        else $error("vector read out of range");
    ins_reserved_a: assert property (rd_ack && wb_adr_i == FIE_A_INS |->
        wb_dat_o[31:8] == 24'h0)
        else $error("in-service upper bits not zero");
    tcfg_reserved_a: assert property (rd_ack && wb_adr_i == FIE_A_TCFG |->
        wb_dat_o[31:8] == 24'h0)
        else $error("trigger config upper bits not zero");
    eclr_layout_a: assert property (rd_ack && wb_adr_i == FIE_A_ECLR |->
        (wb_dat_o & 32'hFFF39FFF) == 32'h0)
        else $error("edge clear read outside clear bits");
    unmapped_zero_a: assert property (rd_ack && wb_adr_i == 32'hFFFF0200 |->
        wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // fie_top_sva

bind fie_top fie_top_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i),
    .ext_pin_i(ext_pin_i), .fiq_o(fiq_o), .irq_o(irq_o), .evt_irq_o(evt_irq_o));

/* fie_top_tb_top.sv */
// Self-checking bench for the fast nesting and trigger block.
// Assumes the package addresses and a 40 MHz single clock.
`timescale 1ns/1ps
module fie_top_tb_top
    import fie_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'hF, pin_cmd = 4'h0, ext_pin_i;
    logic [19:0] src_cmd = 20'h0, src_i;
    logic wb_ack_o, fiq_o, irq_o, evt_irq_o;
    int n_errors = 0, check_count = 0;
    always #12.5 clk_i = ~clk_i;
    fie_src_model i_model (.clk_i(clk_i), .rst_i(rst_i), .pin_cmd_i(pin_cmd),
        .src_cmd_i(src_cmd), .ext_pin_o(ext_pin_i), .src_o(src_i));
    fie_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i), .ext_pin_i(ext_pin_i),
        .fiq_o(fiq_o), .irq_o(irq_o), .evt_irq_o(evt_irq_o));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until ack is sampled at a rising edge, never assumes a latency
    task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        // Released only after the edge that saw ack; the next call idles one cycle
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    // Lets pin and register effects reach the registered outputs
    task automatic settle();
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic drive(input logic [3:0] p, input logic [19:0] s);
        @(posedge clk_i);
        pin_cmd <= p;
        src_cmd <= s;
        settle();
    endtask
    task automatic outs(input logic f, input logic i);
        chk("fiq_o", {31'h0, f}, {31'h0, fiq_o});
        chk("irq_o", {31'h0, i}, {31'h0, irq_o});
    endtask

    task automatic t_reset();
        rdc("trigger reset", FIE_A_TCFG, 32'h0);
        rdc("clear reset", FIE_A_ECLR, 32'h0);
        rdc("in-service reset", FIE_A_INS, 32'h0);
        rdc("unmapped", 32'hFFFF0200, 32'h0);
        wr(FIE_A_TCFG, 32'hE4);
        rdc("trigger field", FIE_A_TCFG, 32'hE4);
        $display("test reset done");
    endtask
    task automatic t_level();
        wr(FIE_A_FEN, 32'h1 << FIE_SRC_EXT0);
        wr(FIE_A_TCFG, {30'h0, FIE_TRG_HIGH});
        drive(4'h1, 20'h0);
        outs(1'b1, 1'b0);
        drive(4'h0, 20'h0);
        outs(1'b0, 1'b0);
        wr(FIE_A_TCFG, {30'h0, FIE_TRG_LOW});
        settle();
        outs(1'b1, 1'b0);
        drive(4'h1, 20'h0);
        outs(1'b0, 1'b0);
        $display("test level done");
    endtask
    task automatic t_edge();
        int clr[4] = '{FIE_CLR_BIT0, FIE_CLR_BIT1, FIE_CLR_BIT2, FIE_CLR_BIT3};
        wr(FIE_A_FEN, 32'h31800);
        wr(FIE_A_TCFG, {24'h0, {4{FIE_TRG_RISE}}});
        wr(FIE_A_EVMSK, 32'hE);
        drive(4'h0, 20'h0);
        outs(1'b0, 1'b0);
        for (int n = 0; n < 4; n++)
        begin
            drive(4'h1 << n, 20'h0);
            outs(1'b1, 1'b0);
            chk("evt_irq_o", (n != 0) ? 32'h1 : 32'h0, {31'h0, evt_irq_o});
            drive(4'h0, 20'h0);
            outs(1'b1, 1'b0);
            wr(FIE_A_ECLR, 32'h1 << clr[n]);
            settle();
            outs(1'b0, 1'b0);
            wr(FIE_A_EVST, 32'hF);
            settle();
            chk("evt_irq_o", 32'h0, {31'h0, evt_irq_o});
        end
        wr(FIE_A_TCFG, {24'h0, {3{FIE_TRG_RISE}}, FIE_TRG_FALL});
        drive(4'h1, 20'h0);
        outs(1'b0, 1'b0);
        drive(4'h0, 20'h0);
        outs(1'b1, 1'b0);
        wr(FIE_A_ECLR, 32'h1 << FIE_CLR_BIT0);
        settle();
        outs(1'b0, 1'b0);
        $display("test edge done");
    endtask
    task automatic t_nest();
        wr(FIE_A_NCON, 32'h1 << FIE_NCON_FAST_BIT);
        wr(FIE_A_FEN, 32'h3);
        wr(FIE_A_PRI0, 32'h52);
        drive(4'h0, 20'h2);
        outs(1'b1, 1'b0);
        rdc("vector", FIE_A_VEC, 32'h4);
        rdc("in-service", FIE_A_INS, 32'h20);
        settle();
        outs(1'b0, 1'b0);
        drive(4'h0, 20'h3);
        outs(1'b1, 1'b0);
        rdc("vector", FIE_A_VEC, 32'h0);
        rdc("in-service", FIE_A_INS, 32'h24);
        settle();
        outs(1'b0, 1'b0);
        wr(FIE_A_INS, 32'hFF);
        rdc("in-service", FIE_A_INS, 32'h20);
        settle();
        outs(1'b1, 1'b0);
        wr(FIE_A_INS, 32'hFF);
        rdc("in-service", FIE_A_INS, 32'h0);
        drive(4'h0, 20'h0);
        $display("test nesting done");
    endtask
    task automatic t_flat();
        wr(FIE_A_NCON, 32'h0);
        wr(FIE_A_FEN, 32'h2);
        wr(FIE_A_NEN, 32'h4);
        drive(4'h0, 20'h6);
        outs(1'b1, 1'b0);
        rdc("flat vector", FIE_A_VEC, 32'h4);
        rdc("flat in-service", FIE_A_INS, 32'h0);
        drive(4'h0, 20'h4);
        outs(1'b0, 1'b1);
        drive(4'h0, 20'h0);
        $display("test flat done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("unexpected watchdog: expected done seen hang");
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_level();
        t_edge();
        t_nest();
        t_flat();
        complete_run();
    end
endmodule // fie_top_tb_top
